// ==== osp_host_model.sv ====
// Purpose: host model issuing decoded commands on the link side
// Assumes: one command outstanding; request changes on falling link_clk
// Notes:   answer awaited for a bounded number of link clocks
module osp_host_model
  import osp_pkg::*;
(
  input  wire logic       link_clk,     // link clock
  output osp_req_s        link_req,     // command word
  output logic            link_req_tgl, // command toggle
  input  wire logic [7:0] link_rdata,   // answer byte
  input  wire logic       link_ack_tgl  // answer toggle
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    link_req = '0;
    link_req_tgl = 1'b0;
  end
  task automatic clear_side();
    link_req_tgl = 1'b0;
  endtask
  task automatic send(input osp_cmd_e c, input logic [9:0] a, input logic [7:0] d,
                      output logic [7:0] r, output logic ok);
    logic was;
    int   n;
    @(negedge link_clk);
    was = link_ack_tgl;
    link_req = '{cmd: c, addr: a, data: d};
    link_req_tgl = ~link_req_tgl;
    n = 0;
    while (link_ack_tgl === was && n < 20) begin
      @(posedge link_clk);
      #1;
      n++;
    end
    r = link_rdata;
    ok = (n < 20);
  endtask
endmodule

// ==== osp_otp_space.sv ====
// Purpose: otp space, parameter space and protection for a serial nor flash
// Assumes: link-side decoder presents one command per toggle on link_clk
// Notes:   commands cross to clk by toggle handshake; answers return by toggle
//
// Behaviour
// - opcode 5ah reads separate parameter space
// - identification tables live inside parameter space
// - parameter space is read-only, writes ignored
// - otp space is 1024 bytes, separate
// - 32 regions of 32 aligned bytes
// - bytes 000-00f random number, unprogrammable
// - lock bits at 010-013, zero locks
// - locked region rejects all programming
// - reserved bytes 014-01f are programmable
// - freeze bit blocks all otp programming
// - freeze stays set until reset
// - volatile bits return to default on reset
// - otp contents survive every reset
// - registers reached only via own commands
// - locked-region program sets program-error flag
// - clear-status command clears program-error flag
// - program ignored while write-enable latch clear
module osp_otp_space
  import osp_pkg::*;
#(
  parameter logic [127:0] RANDOM_VALUE = 128'h0123456789abcdef0f1e2d3c4b5a6978, // arbitrary
  parameter int           PARAM_BYTES  = OSP_PARAM_BYTES
) (
  input  wire logic       clk,          // core clock
  input  wire logic       rst,          // sync reset, high
  input  wire logic       link_clk,     // serial link clock
  input  wire logic       link_rst,     // link-domain sync reset, high
  input  wire osp_req_s   link_req,     // decoded command, held with toggle
  input  wire logic       link_req_tgl, // toggles per new command
  output logic [7:0]      link_rdata,   // read answer byte
  output logic            link_ack_tgl, // toggles when answer ready
  output logic [7:0]      status_reg_one, // status byte
  output logic [7:0]      config_reg_one  // configuration byte
);

  // otp store, not touched by reset
  logic [7:0] otp_mem [OSP_OTP_BYTES];
  logic [7:0] param_rom [PARAM_BYTES];
  logic [7:0] sr1_q, sr1_d;
  logic [7:0] cr1_q, cr1_d;
  logic [7:0] rdata_q, rdata_d;
  logic       ack_tgl_q;

  // link-domain capture of request
  osp_req_s   lreq_q;
  logic       lreq_tgl_q;
  logic [7:0] lack_data_q;
  logic       ack_s1_q, ack_s2_q, ack_s3_q, ack_seen_q;

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      lreq_tgl_q <= 1'b0;
      lreq_q     <= '0;
    end else if (link_req_tgl != lreq_tgl_q) begin
      lreq_tgl_q <= link_req_tgl;
      lreq_q     <= link_req;
    end
  end

  // core-domain sync of request toggle
  logic req_s1_q, req_s2_q, req_s3_q, req_seen_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      req_s1_q   <= 1'b0;
      req_s2_q   <= 1'b0;
      req_s3_q   <= 1'b0;
      req_seen_q <= 1'b0;
    end else begin
      req_s1_q <= lreq_tgl_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      if (req_s2_q == req_s3_q) req_seen_q <= req_s3_q;
    end
  end

  wire       req_go   = (req_s2_q == req_s3_q) && (req_s3_q != req_seen_q);
  osp_req_s  creq;
  assign     creq     = lreq_q; // stable while toggle pending

  // protection decode
  wire [4:0] region     = creq.addr[9:5];
  wire [4:0] lock_idx   = region;
  wire [7:0] lock_byte  = otp_mem[OSP_LOCK_FIRST + {7'h00, lock_idx[4:3]}];
  wire       region_lck = ~lock_byte[lock_idx[2:0]];
  wire       in_random  = creq.addr <= OSP_RAND_LAST;
  wire       frozen     = cr1_q[OSP_CR1_FREEZE];
  wire       write_enable_latch        = sr1_q[OSP_SR1_WEL_BIT];
  wire       is_prog    = req_go && creq.cmd == OSP_CMD_OTP_PROG;
  wire       prog_ok    = is_prog && write_enable_latch;
  wire       rejected   = in_random || region_lck || frozen;
  wire       do_write   = prog_ok && !rejected;
  wire       set_perr   = prog_ok && rejected;

  // command strobes, one cycle each
  wire       is_read    = req_go && creq.cmd == OSP_CMD_OTP_READ;
  wire       is_prd     = req_go && creq.cmd == OSP_CMD_PARAM_RD;
  wire       is_clr     = req_go && creq.cmd == OSP_CMD_CLEAR;
  wire       is_wren    = req_go && creq.cmd == OSP_CMD_WREN;
  wire       is_wrdi    = req_go && creq.cmd == OSP_CMD_WRDI;
  wire       is_wcfg    = req_go && creq.cmd == OSP_CMD_WR_CFG;

  // parameter space holds identification tables, fixed contents
  genvar gi;
  generate
    for (gi = 0; gi < PARAM_BYTES; gi++) begin : g_param
      assign param_rom[gi] = 8'(gi ^ 8'h5a);
    end
  endgenerate

  // shipped contents, written once at power-up only
  initial begin
    for (int i = 0; i < OSP_OTP_BYTES; i++) otp_mem[i] = OSP_ERASED;
    for (int i = 0; i < 16; i++) otp_mem[i] = RANDOM_VALUE[8*i +: 8];
  end

  // otp programming only clears bits; no reset path
  // plain clocked process: shipped image comes from the initial block
  always @(posedge clk) begin
    if (do_write) otp_mem[creq.addr] <= otp_mem[creq.addr] & creq.data;
  end

  always_comb begin
    sr1_d   = sr1_q;
    cr1_d   = cr1_q;
    rdata_d = rdata_q;
    if (req_go) begin
      unique case (creq.cmd)
        OSP_CMD_OTP_READ: rdata_d = otp_mem[creq.addr];
        OSP_CMD_PARAM_RD: rdata_d = (int'(creq.addr) < PARAM_BYTES) ?
                                    param_rom[creq.addr[7:0]] : OSP_ERASED;
        OSP_CMD_CLEAR:    sr1_d[OSP_SR1_PERR_BIT] = 1'b0;
        OSP_CMD_WREN:     sr1_d[OSP_SR1_WEL_BIT] = 1'b1;
        OSP_CMD_WRDI:     sr1_d[OSP_SR1_WEL_BIT] = 1'b0;
        OSP_CMD_WR_CFG:   if (write_enable_latch) begin
          cr1_d[7:1]             = creq.data[7:1];
          cr1_d[OSP_CR1_FREEZE]  = frozen | creq.data[OSP_CR1_FREEZE];
          sr1_d[OSP_SR1_WEL_BIT] = 1'b0;
        end
        OSP_CMD_OTP_PROG: if (do_write) sr1_d[OSP_SR1_WEL_BIT] = 1'b0;
        default: ;
      endcase
    end
    if (set_perr) sr1_d[OSP_SR1_PERR_BIT] = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sr1_q     <= OSP_SR1_RESET;
      cr1_q     <= OSP_CR1_RESET;
      rdata_q   <= 8'h00;
      ack_tgl_q <= 1'b0;
    end else begin
      sr1_q   <= sr1_d;
      cr1_q   <= cr1_d;
      rdata_q <= rdata_d;
      if (req_go) ack_tgl_q <= ~ack_tgl_q;
    end
  end

  assign status_reg_one = sr1_q;
  assign config_reg_one = cr1_q;

  // answer crossing back to link domain
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      ack_s1_q    <= 1'b0;
      ack_s2_q    <= 1'b0;
      ack_s3_q    <= 1'b0;
      ack_seen_q  <= 1'b0;
      lack_data_q <= 8'h00;
    end else begin
      ack_s1_q <= ack_tgl_q;
      ack_s2_q <= ack_s1_q;
      ack_s3_q <= ack_s2_q;
      if (ack_s2_q == ack_s3_q && ack_s3_q != ack_seen_q) begin
        ack_seen_q  <= ack_s3_q;
        lack_data_q <= rdata_q;
      end
    end
  end

  assign link_rdata   = lack_data_q;
  assign link_ack_tgl = ack_seen_q;

  a_perr_on_lock: assert property (@(posedge clk) disable iff (rst)
    set_perr |=> sr1_q[OSP_SR1_PERR_BIT])
    else $error("program error not raised on rejected program");
  a_perr_clear: assert property (@(posedge clk) disable iff (rst)
    (req_go && creq.cmd == OSP_CMD_CLEAR && !set_perr) |=> !sr1_q[OSP_SR1_PERR_BIT])
    else $error("clear status left program error set");
  a_freeze_sticky: assert property (@(posedge clk) disable iff (rst)
    cr1_q[OSP_CR1_FREEZE] |=> cr1_q[OSP_CR1_FREEZE])
    else $error("freeze bit dropped without reset");
  a_freeze_blocks: assert property (@(posedge clk) disable iff (rst)
    frozen |-> !do_write)
    else $error("otp write while frozen");
  a_random_guard: assert property (@(posedge clk) disable iff (rst)
    (is_prog && creq.addr <= OSP_RAND_LAST) |-> !do_write)
    else $error("random bytes written");
  a_lock_guard: assert property (@(posedge clk) disable iff (rst)
    (is_prog && region_lck) |-> !do_write)
    else $error("locked region written");
  a_wel_guard: assert property (@(posedge clk) disable iff (rst)
    (is_prog && !write_enable_latch) |=> $stable(sr1_q))
    else $error("program acted without write enable");
  a_rsvd_prog: assert property (@(posedge clk) disable iff (rst)
    (prog_ok && !frozen && !region_lck && creq.addr >= OSP_RSVD_FIRST
     && creq.addr <= OSP_RSVD_LAST) |-> do_write)
    else $error("reserved byte program refused");
  a_reset_vals: assert property (@(posedge clk)
    $past(rst) |-> (sr1_q == OSP_SR1_RESET && cr1_q == OSP_CR1_RESET))
    else $error("volatile registers not at default after reset");

  // read path and answer checks
  a_read_otp_data: assert property (@(posedge clk) disable iff (rst)
    is_read |=> rdata_q == $past(otp_mem[creq.addr]))
    else $error("otp read returned wrong byte");

  a_param_read_data: assert property (@(posedge clk) disable iff (rst)
    (is_prd && int'(creq.addr) < PARAM_BYTES) |=> rdata_q == $past(param_rom[creq.addr[7:0]]))
    else $error("parameter read returned wrong byte");

  a_param_beyond_end: assert property (@(posedge clk) disable iff (rst)
    (is_prd && int'(creq.addr) >= PARAM_BYTES) |=> rdata_q == OSP_ERASED)
    else $error("parameter read past end not erased value");

  a_rdata_hold: assert property (@(posedge clk) disable iff (rst)
    !(is_read || is_prd) |=> $stable(rdata_q))
    else $error("answer byte changed without a read");

  a_ack_per_go: assert property (@(posedge clk) disable iff (rst)
    req_go |=> ack_tgl_q != $past(ack_tgl_q))
    else $error("command not answered");

  a_ack_idle: assert property (@(posedge clk) disable iff (rst)
    !req_go |=> $stable(ack_tgl_q))
    else $error("answer toggled without command");

  a_go_one_cycle: assert property (@(posedge clk) disable iff (rst)
    req_go |=> !req_go)
    else $error("command executed twice");

  // write-enable latch checks
  a_wren_sets: assert property (@(posedge clk) disable iff (rst)
    is_wren |=> sr1_q[OSP_SR1_WEL_BIT])
    else $error("write enable not set");

  a_wrdi_clears: assert property (@(posedge clk) disable iff (rst)
    is_wrdi |=> !sr1_q[OSP_SR1_WEL_BIT])
    else $error("write disable left latch set");

  a_prog_drops_wel: assert property (@(posedge clk) disable iff (rst)
    do_write |=> !sr1_q[OSP_SR1_WEL_BIT])
    else $error("latch kept after good program");

  a_reject_keeps_wel: assert property (@(posedge clk) disable iff (rst)
    set_perr |=> sr1_q[OSP_SR1_WEL_BIT])
    else $error("latch dropped on rejected program");

  a_wel_hold: assert property (@(posedge clk) disable iff (rst)
    (!is_wren && !is_wrdi && !do_write && !(is_wcfg && write_enable_latch))
    |=> sr1_q[OSP_SR1_WEL_BIT] == $past(sr1_q[OSP_SR1_WEL_BIT]))
    else $error("latch changed without cause");

  a_write_needs_wel: assert property (@(posedge clk) disable iff (rst)
    do_write |-> write_enable_latch)
    else $error("otp written without write enable");

  a_idle_no_write: assert property (@(posedge clk) disable iff (rst)
    !req_go |-> !do_write)
    else $error("otp written without command");

  // configuration checks
  a_cfg_needs_wel: assert property (@(posedge clk) disable iff (rst)
    (is_wcfg && !write_enable_latch) |=> $stable(cr1_q))
    else $error("config written without write enable");

  a_cfg_upper: assert property (@(posedge clk) disable iff (rst)
    (is_wcfg && write_enable_latch) |=> cr1_q[7:1] == $past(creq.data[7:1]))
    else $error("config upper bits not stored");

  a_cfg_wel_clear: assert property (@(posedge clk) disable iff (rst)
    (is_wcfg && write_enable_latch) |=> !sr1_q[OSP_SR1_WEL_BIT])
    else $error("latch kept after config write");

  a_freeze_set: assert property (@(posedge clk) disable iff (rst)
    (is_wcfg && write_enable_latch && creq.data[OSP_CR1_FREEZE]) |=> cr1_q[OSP_CR1_FREEZE])
    else $error("freeze bit not set");

  a_cfg_freeze_keep: assert property (@(posedge clk) disable iff (rst)
    (is_wcfg && frozen) |=> cr1_q[OSP_CR1_FREEZE])
    else $error("config write cleared freeze");

  a_cr1_idle: assert property (@(posedge clk) disable iff (rst)
    !is_wcfg |=> $stable(cr1_q))
    else $error("config changed without config write");

  // status and otp content checks
  a_sr1_spare_zero: assert property (@(posedge clk) disable iff (rst)
    (sr1_q & ~8'h42) == 8'h00)
    else $error("unused status bit set");

  a_perr_source: assert property (@(posedge clk) disable iff (rst)
    !set_perr |=> !$rose(sr1_q[OSP_SR1_PERR_BIT]))
    else $error("program error raised without cause");

  a_perr_hold: assert property (@(posedge clk) disable iff (rst)
    (sr1_q[OSP_SR1_PERR_BIT] && !is_clr) |=> sr1_q[OSP_SR1_PERR_BIT])
    else $error("program error dropped without clear");

  a_read_no_sr1: assert property (@(posedge clk) disable iff (rst)
    (is_read || is_prd) |=> $stable(sr1_q))
    else $error("read changed status");

  a_otp_and_only: assert property (@(posedge clk) disable iff (rst)
    do_write |=> otp_mem[$past(creq.addr)] == ($past(otp_mem[creq.addr]) & $past(creq.data)))
    else $error("otp program did more than clear bits");

  a_random_fixed: assert property (@(posedge clk) disable iff (rst)
    $stable(otp_mem[OSP_RAND_LAST]))
    else $error("random byte changed");

  // link-domain checks
  a_link_capture: assert property (@(posedge link_clk) disable iff (link_rst)
    (link_req_tgl != lreq_tgl_q) |=> lreq_tgl_q == $past(link_req_tgl))
    else $error("link command not captured");

  a_link_req_hold: assert property (@(posedge link_clk) disable iff (link_rst)
    (link_req_tgl == lreq_tgl_q) |=> $stable(lreq_q))
    else $error("captured command changed while idle");

  a_ack_data_hold: assert property (@(posedge link_clk) disable iff (link_rst)
    $stable(ack_seen_q) |-> $stable(lack_data_q))
    else $error("answer byte changed without answer");

  a_ack_data_val: assert property (@(posedge link_clk) disable iff (link_rst)
    $changed(ack_seen_q) |-> lack_data_q == $past(rdata_q))
    else $error("answer byte not taken with answer");

endmodule

// ==== osp_pkg.sv ====
// Purpose: constants and types for the otp and parameter-space block
// Assumes: serial commands arrive already decoded into requests held with a toggle
// Notes:   byte offsets are within the otp space
package osp_pkg;

  localparam int          OSP_OTP_BYTES     = 1024;
  localparam int          OSP_REGION_BYTES  = 32;
  localparam int          OSP_REGIONS       = 32;
  localparam int          OSP_PARAM_BYTES   = 256;
  localparam logic [9:0]  OSP_RAND_LAST     = 10'h00f;
  localparam logic [9:0]  OSP_LOCK_FIRST    = 10'h010;
  localparam logic [9:0]  OSP_LOCK_LAST     = 10'h013;
  localparam logic [9:0]  OSP_RSVD_FIRST    = 10'h014;
  localparam logic [9:0]  OSP_RSVD_LAST     = 10'h01f;
  localparam logic [7:0]  OSP_ERASED        = 8'hff;
  localparam logic [7:0]  OSP_OP_PARAM_READ = 8'h5a;
  localparam logic [7:0]  OSP_OP_CLEAR_STAT = 8'h30;
  localparam int          OSP_SR1_PERR_BIT  = 6;
  localparam int          OSP_SR1_WEL_BIT   = 1;
  localparam int          OSP_CR1_FREEZE    = 0;
  localparam logic [7:0]  OSP_SR1_RESET     = 8'h00;
  localparam logic [7:0]  OSP_CR1_RESET     = 8'h00;

  typedef enum logic [2:0] {
    OSP_CMD_NONE      = 3'b000,
    OSP_CMD_OTP_READ  = 3'b001,
    OSP_CMD_OTP_PROG  = 3'b010,
    OSP_CMD_PARAM_RD  = 3'b011,
    OSP_CMD_CLEAR     = 3'b100,
    OSP_CMD_WREN      = 3'b101,
    OSP_CMD_WRDI      = 3'b110,
    OSP_CMD_WR_CFG    = 3'b111
  } osp_cmd_e;

  typedef struct packed {
    osp_cmd_e    cmd;
    logic [9:0]  addr;
    logic [7:0]  data;
  } osp_req_s;

endpackage

// ==== tb_top.sv ====
// Purpose: self-checking bench for the otp and parameter space
// Assumes: host model drives the link side
// Notes:   expectations from package constants and the random value
module tb_top;
  import osp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [127:0] RND = 128'h8899aabbccddeeff0011223344556677; // arbitrary
  logic       clk, rst, link_clk, link_rst, link_req_tgl, link_ack_tgl, ok;
  osp_req_s   link_req;
  logic [7:0] link_rdata, sr1, cr1, rd;
  int         bad_count, n_tests, cycles;
  osp_otp_space #(.RANDOM_VALUE(RND)) dut (.clk(clk), .rst(rst), .link_clk(link_clk),
    .link_rst(link_rst), .link_req(link_req), .link_req_tgl(link_req_tgl),
    .link_rdata(link_rdata), .link_ack_tgl(link_ack_tgl), .status_reg_one(sr1),
    .config_reg_one(cr1));
  osp_host_model host (.link_clk(link_clk), .link_req(link_req),
    .link_req_tgl(link_req_tgl), .link_rdata(link_rdata), .link_ack_tgl(link_ack_tgl));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #3;
    forever #40 link_clk = ~link_clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic c(input osp_cmd_e k, input logic [9:0] a, input logic [7:0] d);
    host.send(k, a, d, rd, ok);
    if (!ok) begin
      bad_count++;
      $display("[ERR] %0t no answer", $time);
    end
  endtask
  task automatic prog(input logic [9:0] a, input logic [7:0] d);
    c(OSP_CMD_WREN, 10'h000, 8'h00);
    c(OSP_CMD_OTP_PROG, a, d);
  endtask
  task automatic rdchk(input logic [9:0] a, input logic [7:0] e);
    c(OSP_CMD_OTP_READ, a, 8'h00);
    chk(rd, e);
  endtask
  task automatic do_reset();
    @(negedge clk);
    rst = 1'b1;
    link_rst = 1'b1;
    host.clear_side();
    // link side must be in reset before the core leaves it
    repeat (2) @(negedge link_clk);
    repeat (4) @(negedge clk);
    rst = 1'b0;
    @(negedge link_clk);
    link_rst = 1'b0;
    repeat (2) @(posedge link_clk);
  endtask
  task automatic t_reset();
    chk(sr1, OSP_SR1_RESET);
    chk(cr1, OSP_CR1_RESET);
    rdchk(10'h010, OSP_ERASED);
    rdchk(10'h014, OSP_ERASED);
    rdchk(10'h3ff, OSP_ERASED);
    rdchk(10'h000, RND[7:0]);
    rdchk(10'h00f, RND[127:120]);
    $display("test reset done");
  endtask
  task automatic t_param();
    c(OSP_CMD_PARAM_RD, 10'h000, 8'h00);
    chk(rd, 8'h5a);
    c(OSP_CMD_PARAM_RD, 10'h0f5, 8'h00);
    chk(rd, 8'haf);
    c(OSP_CMD_PARAM_RD, 10'h100, 8'h00);
    chk(rd, 8'hff);
    $display("test param done");
  endtask
  task automatic t_wel();
    c(OSP_CMD_OTP_PROG, 10'h020, 8'h5a);
    rdchk(10'h020, OSP_ERASED);
    prog(10'h020, 8'h5a);
    chk(sr1, 8'h00);
    rdchk(10'h020, 8'h5a);
    prog(10'h020, 8'hf0);
    rdchk(10'h020, 8'h50);
    $display("test wel done");
  endtask
  task automatic t_reject();
    prog(10'h000, 8'h00);
    chk(sr1, 8'h42);
    rdchk(10'h000, RND[7:0]);
    c(OSP_CMD_CLEAR, 10'h000, 8'h00);
    chk(sr1, 8'h02);
    c(OSP_CMD_WRDI, 10'h000, 8'h00);
    chk(sr1, 8'h00);
    $display("test reject done");
  endtask
  task automatic t_lock();
    prog(10'h010, 8'hfd);
    rdchk(10'h010, 8'hfd);
    prog(10'h03f, 8'h00);
    chk(sr1, 8'h42);
    rdchk(10'h03f, OSP_ERASED);
    c(OSP_CMD_CLEAR, 10'h000, 8'h00);
    c(OSP_CMD_WRDI, 10'h000, 8'h00);
    prog(10'h040, 8'h11);
    rdchk(10'h040, 8'h11);
    prog(10'h01f, 8'h00);
    rdchk(10'h01f, 8'h00);
    $display("test lock done");
  endtask
  task automatic t_freeze();
    c(OSP_CMD_WREN, 10'h000, 8'h00);
    c(OSP_CMD_WR_CFG, 10'h000, 8'h01);
    chk(cr1, 8'h01);
    prog(10'h060, 8'h00);
    chk(sr1, 8'h42);
    c(OSP_CMD_WR_CFG, 10'h000, 8'h00);
    chk(cr1, 8'h01);
    do_reset();
    chk(cr1, OSP_CR1_RESET);
    chk(sr1, OSP_SR1_RESET);
    rdchk(10'h020, 8'h50);
    prog(10'h060, 8'h00);
    rdchk(10'h060, 8'h00);
    $display("test freeze done");
  endtask
  initial begin
    rst = 1'b1;
    link_rst = 1'b1;
    bad_count = 0;
    n_tests = 0;
    cycles = 0;
    do_reset();
    t_reset();
    t_param();
    t_wel();
    t_reject();
    t_lock();
    t_freeze();
    print_verdict();
  end
endmodule
